// ==== gpei_params.svh ====
`ifndef GPEI_PARAMS_SVH
`define GPEI_PARAMS_SVH

// Register indices; byte address is four times the index
`define GPEI_IDX_A_DATA   6'h00
`define GPEI_IDX_A_DIR    6'h01
`define GPEI_IDX_B_DATA   6'h02
`define GPEI_IDX_B_DIR    6'h03
`define GPEI_IDX_C_DATA   6'h04
`define GPEI_IDX_C_DIR    6'h05
`define GPEI_IDX_IRQ_EN   6'h08
`define GPEI_IDX_PENDING  6'h0A

// Reset values
`define GPEI_RST_LATCH    8'h00
`define GPEI_RST_DIR      8'h00
`define GPEI_RST_IRQ_EN   8'h00
`define GPEI_RST_C_LOW    3'h0

// Port C has three pins; the upper data bits read as ones
`define GPEI_C_UNUSED     8'hF8

// Interrupt line layout: bit k is line k+1, lines 1,2,5,6 rising
`define GPEI_RISE_MASK    8'h33

// Bus responses
`define GPEI_RESP_OKAY    2'h0
`define GPEI_RESP_SLVERR  2'h2

`endif

// ==== gpei_pkg.sv ====
package gpei_pkg;

   // Alternate function request from on-chip peripherals, one bit per pin
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] value;
      logic [7:0] od;
   } gpei_alt_t;

   // Edge detector state
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } gpei_edge_st_t;

   // Whole state of the top module
   typedef struct packed {
      logic       awready;
      logic       aw_held;
      logic [5:0] aw_idx;
      logic       wready;
      logic       w_held;
      logic [7:0] wdata;
      logic       wstrb0;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [7:0] latch_a;
      logic [7:0] latch_b;
      logic [2:0] latch_c;
      logic [7:0] dir_a;
      logic [7:0] dir_b;
      logic [2:0] dir_c;
      logic [7:0] irq_en;
      logic [7:0] pending;
      logic       irq_req;
      logic [7:0] out_a;
      logic [7:0] oe_a;
      logic [7:0] out_b;
      logic [7:0] oe_b;
      logic [2:0] out_c;
      logic [2:0] oe_c;
      logic [7:0] analog_sel;
   } gpei_state_t;

endpackage

// ==== gpei_edge_det.sv ====
`timescale 1ns/10ps
module gpei_edge_det #(
   parameter bit RISING = 1'b1
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   input  wire logic pin,
   input  wire logic enable,
   input  wire logic inhibit,
   output logic      prev_level,
   output logic      pulse
);
   gpei_pkg::gpei_edge_st_t st_ff;
   gpei_pkg::gpei_edge_st_t nxt_st;

   // Two-stage synchroniser then one sample of history
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.s1   = pin;
      nxt_st.s2   = st_ff.s1;
      nxt_st.prev = st_ff.s2;
   end

   // Idle level at reset avoids a false edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= RISING ? 3'b000 : 3'b111;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // Single-cycle detect, gated by enable and output inhibit
   assign prev_level = st_ff.prev;
   assign pulse = enable && !inhibit &&
                  (RISING ? (st_ff.s2 && !st_ff.prev) : (!st_ff.s2 && st_ff.prev));
endmodule

// ==== gpei_pin_mux.sv ====
`timescale 1ns/10ps
module gpei_pin_mux #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] latch,
   input  wire logic [W-1:0] dir,
   input  wire logic [W-1:0] drive,
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] od,
   output logic      [W-1:0] eff_out,
   output logic      [W-1:0] pin_out,
   output logic      [W-1:0] pin_oe
);
   // Peripheral drive overrides the latch and the direction bit
   assign eff_out = dir | drive;
   assign pin_out = (drive & value & ~od) | (~drive & latch);
   // Open drain only pulls low; push-pull always drives
   assign pin_oe  = (drive & (~od | ~value)) | (~drive & dir);
endmodule

// ==== gpei_top.sv ====
// Summary of operation
// - Enabled rising edge on lines 1,2,5,6 requests
// - Enabled falling edge on lines 3,4,7,8 requests
// - No request from disabled or other pins
// - Direction bit per pin: 0 input, 1 output
// - Input pin read returns pin level
// - Each line detects its own edge unless a held line of its group masks it
// - Enabled lines ORed; held level masks group
// - Output pin drives latch; read returns latch
// - Output pins raise no interrupt
// - Peripheral function overrides data and direction
// - Peripheral drive forces output, push-pull or open-drain
// - Peripheral input pins stay readable as inputs
// - Only the selected analog pin reaches converter
// - Request reaches CPU only while mask clear
// - All eight lines share one request vector
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "gpei_params.svh"
module gpei_top (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                ce,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic [7:0]          pin_a_in,
   output logic [7:0]               pin_a_out,
   output logic [7:0]               pin_a_oe,
   input  wire logic [7:0]          pin_b_in,
   output logic [7:0]               pin_b_out,
   output logic [7:0]               pin_b_oe,
   input  wire logic [2:0]          pin_c_in,
   output logic [2:0]               pin_c_out,
   output logic [2:0]               pin_c_oe,
   input  wire gpei_pkg::gpei_alt_t alt_a,
   input  wire gpei_pkg::gpei_alt_t alt_b,
   input  wire gpei_pkg::gpei_alt_t alt_c,
   input  wire logic                adc_enable,
   input  wire logic [2:0]          adc_channel,
   input  wire logic                cpu_irq_mask,
   input  wire logic                irq_ack,
   output logic                     irq_req,
   output logic [7:0]               analog_sel
);
   gpei_pkg::gpei_state_t st_ff;
   gpei_pkg::gpei_state_t nxt_st;

   logic [7:0] eff_a;
   logic [7:0] eff_b;
   logic [2:0] eff_c;
   logic [7:0] mux_out_a;
   logic [7:0] mux_oe_a;
   logic [7:0] mux_out_b;
   logic [7:0] mux_oe_b;
   logic [2:0] mux_out_c;
   logic [2:0] mux_oe_c;
   logic [7:0] line_pin;
   logic [7:0] line_inhibit;
   logic [7:0] line_prev;
   logic [7:0] line_pulse;
   logic [7:0] line_held;
   logic [7:0] accept;
   logic [7:0] rd_val;
   logic       rd_ok;
   logic [7:0] w1c;
   logic       wr_ok;

   // Pin multiplexers, one per port
   gpei_pin_mux #(.W(8)) u_mux_a (
      .latch   (st_ff.latch_a),
      .dir     (st_ff.dir_a),
      .drive   (alt_a.drive),
      .value   (alt_a.value),
      .od      (alt_a.od),
      .eff_out (eff_a),
      .pin_out (mux_out_a),
      .pin_oe  (mux_oe_a)
   );

   gpei_pin_mux #(.W(8)) u_mux_b (
      .latch   (st_ff.latch_b),
      .dir     (st_ff.dir_b),
      .drive   (alt_b.drive),
      .value   (alt_b.value),
      .od      (alt_b.od),
      .eff_out (eff_b),
      .pin_out (mux_out_b),
      .pin_oe  (mux_oe_b)
   );

   gpei_pin_mux #(.W(3)) u_mux_c (
      .latch   (st_ff.latch_c),
      .dir     (st_ff.dir_c),
      .drive   (alt_c.drive[2:0]),
      .value   (alt_c.value[2:0]),
      .od      (alt_c.od[2:0]),
      .eff_out (eff_c),
      .pin_out (mux_out_c),
      .pin_oe  (mux_oe_c)
   );

   // Interrupt lines sit on the upper halves of ports A and B
   assign line_pin     = {pin_b_in[7:4], pin_a_in[7:4]};
   assign line_inhibit = {eff_b[7:4], eff_a[7:4]};

   // One edge detector per line, polarity fixed per line
   for (genvar k = 0; k < 8; k++) begin : g_line
      localparam logic [7:0] RISE_MASK = `GPEI_RISE_MASK;
      localparam bit         RISE      = RISE_MASK[k];
      logic grp_block;

      gpei_edge_det #(.RISING(RISE)) u_edge (
         .aclk       (aclk),
         .aresetn    (aresetn),
         .ce         (ce),
         .pin        (line_pin[k]),
         .enable     (st_ff.irq_en[k]),
         .inhibit    (line_inhibit[k]),
         .prev_level (line_prev[k]),
         .pulse      (line_pulse[k])
      );

      // Line already asserted in its wired group
      assign line_held[k] = st_ff.irq_en[k] && !line_inhibit[k] &&
                            (RISE ? line_prev[k] : !line_prev[k]);
      // Another asserted line of the same polarity hides this edge
      assign grp_block = |(line_held & ~(8'h01 << k) &
                           (RISE ? `GPEI_RISE_MASK : ~`GPEI_RISE_MASK));
      assign accept[k] = line_pulse[k] && !grp_block;
   end

   // Read decode; inputs read the pin, outputs the latch
   always_comb begin
      rd_val = 8'h00;
      rd_ok  = 1'b1;
      unique case (s_axi_araddr[7:2])
         `GPEI_IDX_A_DATA:  rd_val = (st_ff.latch_a & eff_a) | (pin_a_in & ~eff_a);
         `GPEI_IDX_A_DIR:   rd_val = st_ff.dir_a;
         `GPEI_IDX_B_DATA:  rd_val = (st_ff.latch_b & eff_b) | (pin_b_in & ~eff_b);
         `GPEI_IDX_B_DIR:   rd_val = st_ff.dir_b;
         `GPEI_IDX_C_DATA:  rd_val = `GPEI_C_UNUSED |
                                     {5'h00, (st_ff.latch_c & eff_c) | (pin_c_in & ~eff_c)};
         `GPEI_IDX_C_DIR:   rd_val = `GPEI_C_UNUSED | {5'h00, st_ff.dir_c};
         `GPEI_IDX_IRQ_EN:  rd_val = st_ff.irq_en;
         `GPEI_IDX_PENDING: rd_val = st_ff.pending;
         default:           rd_ok  = 1'b0;
      endcase
   end

   // Write target check
   always_comb begin
      unique case (st_ff.aw_idx)
         `GPEI_IDX_A_DATA, `GPEI_IDX_A_DIR, `GPEI_IDX_B_DATA, `GPEI_IDX_B_DIR,
         `GPEI_IDX_C_DATA, `GPEI_IDX_C_DIR, `GPEI_IDX_IRQ_EN,
         `GPEI_IDX_PENDING: wr_ok = 1'b1;
         default:           wr_ok = 1'b0;
      endcase
   end

   // Next state
   always_comb begin
      nxt_st = st_ff;
      w1c    = 8'h00;

      // Write address channel, one-cycle ready
      nxt_st.awready = 1'b0;
      if (st_ff.awready) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.aw_idx  = s_axi_awaddr[7:2];
      end else if (!st_ff.aw_held && s_axi_awvalid) begin
         nxt_st.awready = 1'b1;
      end

      // Write data channel, one-cycle ready
      nxt_st.wready = 1'b0;
      if (st_ff.wready) begin
         nxt_st.w_held = 1'b1;
         nxt_st.wdata  = s_axi_wdata[7:0];
         nxt_st.wstrb0 = s_axi_wstrb[0];
      end else if (!st_ff.w_held && s_axi_wvalid) begin
         nxt_st.wready = 1'b1;
      end

      // Write response
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // Commit once both halves are held and no response waits
      if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held  = 1'b0;
         nxt_st.bvalid  = 1'b1;
         nxt_st.bresp   = wr_ok ? `GPEI_RESP_OKAY : `GPEI_RESP_SLVERR;
         if (st_ff.wstrb0) begin
            unique case (st_ff.aw_idx)
               `GPEI_IDX_A_DATA:  nxt_st.latch_a = st_ff.wdata;
               `GPEI_IDX_A_DIR:   nxt_st.dir_a   = st_ff.wdata;
               `GPEI_IDX_B_DATA:  nxt_st.latch_b = st_ff.wdata;
               `GPEI_IDX_B_DIR:   nxt_st.dir_b   = st_ff.wdata;
               `GPEI_IDX_C_DATA:  nxt_st.latch_c = st_ff.wdata[2:0];
               `GPEI_IDX_C_DIR:   nxt_st.dir_c   = st_ff.wdata[2:0];
               `GPEI_IDX_IRQ_EN:  nxt_st.irq_en  = st_ff.wdata;
               `GPEI_IDX_PENDING: w1c            = st_ff.wdata;
               default:           ;
            endcase
         end
      end

      // Read channel: ready one cycle, data the cycle after
      nxt_st.arready = 1'b0;
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (st_ff.arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = rd_val;
         nxt_st.rresp  = rd_ok ? `GPEI_RESP_OKAY : `GPEI_RESP_SLVERR;
      end else if (!st_ff.rvalid && s_axi_arvalid) begin
         nxt_st.arready = 1'b1;
      end

      // Pending stays latched while masked; a new edge beats a clear
      nxt_st.pending = (st_ff.pending & ~(irq_ack ? 8'hFF : w1c)) | accept;
      nxt_st.irq_req = (|st_ff.pending) && !cpu_irq_mask;

      // Registered pin drive
      nxt_st.out_a = mux_out_a;
      nxt_st.oe_a  = mux_oe_a;
      nxt_st.out_b = mux_out_b;
      nxt_st.oe_b  = mux_oe_b;
      nxt_st.out_c = mux_out_c;
      nxt_st.oe_c  = mux_oe_c;

      // Analog multiplexer: at most the selected port B pin
      nxt_st.analog_sel = adc_enable ? (8'h01 << adc_channel) : 8'h00;
   end

   // State register with clock enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff         <= '0;
         st_ff.latch_a <= `GPEI_RST_LATCH;
         st_ff.latch_b <= `GPEI_RST_LATCH;
         st_ff.latch_c <= `GPEI_RST_C_LOW;
         st_ff.dir_a   <= `GPEI_RST_DIR;
         st_ff.dir_b   <= `GPEI_RST_DIR;
         st_ff.dir_c   <= `GPEI_RST_C_LOW;
         st_ff.irq_en  <= `GPEI_RST_IRQ_EN;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready  = st_ff.wready;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rresp   = st_ff.rresp;
   assign s_axi_rdata   = {24'h000000, st_ff.rdata};
   assign pin_a_out     = st_ff.out_a;
   assign pin_a_oe      = st_ff.oe_a;
   assign pin_b_out     = st_ff.out_b;
   assign pin_b_oe      = st_ff.oe_b;
   assign pin_c_out     = st_ff.out_c;
   assign pin_c_oe      = st_ff.oe_c;
   assign irq_req       = st_ff.irq_req;
   assign analog_sel    = st_ff.analog_sel;

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);

   sequence seq_read_a_input;
      st_ff.arready && s_axi_araddr[7:2] == `GPEI_IDX_A_DATA &&
      st_ff.dir_a == 8'h00 && alt_a.drive == 8'h00;
   endsequence

   sequence seq_rise_line1;
      accept[0] ##1 1'b1;
   endsequence

   a_rise_sets_pending: assert property (seq_rise_line1 |-> st_ff.pending[0])
      else $error("rising edge on line 1 not latched");

   a_fall_sets_pending: assert property (accept[2] |=> st_ff.pending[2])
      else $error("falling edge on line 3 not latched");

   a_disabled_no_set: assert property (1'b1 |=>
      (st_ff.pending & ~$past(st_ff.pending) & ~$past(st_ff.irq_en)) == 8'h00)
      else $error("pending set on a disabled line");

   a_input_read_pin: assert property (seq_read_a_input |=>
      st_ff.rvalid && st_ff.rdata == $past(pin_a_in))
      else $error("input read did not return pin level");

   a_output_drives_latch: assert property (
      st_ff.dir_a[0] && !alt_a.drive[0] |=>
      pin_a_oe[0] && pin_a_out[0] == $past(st_ff.latch_a[0]))
      else $error("output pin does not follow latch");

   a_output_no_irq: assert property (st_ff.dir_a[4] |-> !line_pulse[0])
      else $error("edge reported on output pin");

   a_alt_forces_out: assert property (
      alt_b.drive[1] && !alt_b.od[1] |=>
      pin_b_oe[1] && pin_b_out[1] == $past(alt_b.value[1]))
      else $error("peripheral drive not forced onto pin");

   a_open_drain_low: assert property (
      alt_a.drive[2] && alt_a.od[2] && alt_a.value[2] |=> !pin_a_oe[2])
      else $error("open drain pin drove high");

   a_mask_blocks_irq: assert property (cpu_irq_mask |=> !irq_req)
      else $error("request passed while mask set");

   a_or_request: assert property (
      !cpu_irq_mask && |st_ff.pending ##1 1'b1 |-> irq_req)
      else $error("pending line did not raise shared request");

   a_analog_one_pin: assert property (1'b1 |=> $onehot0(analog_sel))
      else $error("more than one analog pin selected");
endmodule

// ==== gpei_pin_model.sv ====
`timescale 1ns/10ps
// Board side of the pins: pull-ups on ports A and C, port B floats
module gpei_pin_model (
   input  wire logic        aclk,
   input  wire logic [7:0]  a_out,
   input  wire logic [7:0]  a_oe,
   input  wire logic [7:0]  b_out,
   input  wire logic [7:0]  b_oe,
   input  wire logic [2:0]  c_out,
   input  wire logic [2:0]  c_oe,
   input  wire logic [23:0] ext_en,
   input  wire logic [23:0] ext,
   output logic      [7:0]  a_in,
   output logic      [7:0]  b_in,
   output logic      [2:0]  c_in
);
   logic [7:0]  churn = 8'h00;
   logic [23:0] brd;

   // Released floating lines wander every cycle
   always @(posedge aclk) begin
      churn <= churn + 8'h5B;
   end

   // Wire level: device drive, else board driver, else pull or float
   always_comb begin
      brd = (ext_en & ext) | (~ext_en & {8'hFF, churn, 8'hFF});
      a_in = (a_oe & a_out) | (~a_oe & brd[7:0]);
      b_in = (b_oe & b_out) | (~b_oe & brd[15:8]);
      c_in = (c_oe & c_out) | (~c_oe & brd[18:16]);
   end
endmodule

// ==== test_gpio_port_edge_interrupt.sv ====
`timescale 1ns/10ps
`include "gpei_params.svh"
module test_gpio_port_edge_interrupt;
   localparam logic [7:0] en_addr   = {`GPEI_IDX_IRQ_EN, 2'h0};
   localparam logic [7:0] pend_addr = {`GPEI_IDX_PENDING, 2'h0};
   logic                aclk = 1'b0;
   logic                aresetn = 1'b0;
   logic                ce = 1'b1;
   logic [7:0]          s_axi_awaddr = 8'h00;
   logic [7:0]          s_axi_araddr = 8'h00;
   logic [31:0]         s_axi_wdata = 32'h0;
   logic [3:0]          s_axi_wstrb = 4'h0;
   logic                s_axi_awvalid = 1'b0;
   logic                s_axi_wvalid = 1'b0;
   logic                s_axi_bready = 1'b0;
   logic                s_axi_arvalid = 1'b0;
   logic                s_axi_rready = 1'b0;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic                s_axi_rvalid, irq_req;
   logic [1:0]          s_axi_bresp, s_axi_rresp, rs;
   logic [31:0]         s_axi_rdata, rv;
   logic [7:0]          pin_a_in, pin_a_out, pin_a_oe, pin_b_in, pin_b_out, pin_b_oe;
   logic [7:0]          analog_sel;
   logic [2:0]          pin_c_in, pin_c_out, pin_c_oe;
   gpei_pkg::gpei_alt_t alt_a = '0;
   gpei_pkg::gpei_alt_t alt_b = '0;
   gpei_pkg::gpei_alt_t alt_c = '0;
   logic                adc_enable = 1'b0;
   logic [2:0]          adc_channel = 3'h0;
   logic                cpu_irq_mask = 1'b0;
   logic                irq_ack = 1'b0;
   logic [23:0]         ext_en = 24'hFFFFFF;
   logic [23:0]         ext = 24'h00C0C0;
   logic [7:0]          m_lat [3];
   logic [7:0]          m_dir [3];
   int                  fails = 0;
   int                  check_count = 0;
   int                  ln, pb;

   // Clock
   always #12.5 aclk = ~aclk;

   gpei_top DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_a_in, .pin_a_out, .pin_a_oe,
      .pin_b_in, .pin_b_out, .pin_b_oe, .pin_c_in, .pin_c_out, .pin_c_oe, .alt_a, .alt_b,
      .alt_c, .adc_enable, .adc_channel, .cpu_irq_mask, .irq_ack, .irq_req, .analog_sel);

   gpei_pin_model PM (.aclk(aclk), .a_out(pin_a_out), .a_oe(pin_a_oe), .b_out(pin_b_out),
      .b_oe(pin_b_oe), .c_out(pin_c_out), .c_oe(pin_c_oe), .ext_en(ext_en), .ext(ext),
      .a_in(pin_a_in), .b_in(pin_b_in), .c_in(pin_c_in));

   // Verdict and end of run
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Value compare
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Response compare
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD at %0t: response %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Register write; response lands in rs
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st = 4'hF);
      int   t;
      logic aw, w;
      t = 0;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w && s_axi_bvalid === 1'b1) && t < 100) begin
         @(posedge aclk);
         t++;
         if (s_axi_awvalid && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      if (t >= 100) fails++;
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // Register read; data in rv, response in rs
   task automatic rd(input logic [7:0] a);
      int t;
      t = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (s_axi_rvalid !== 1'b1 && t < 100) begin
         @(posedge aclk);
         t++;
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      if (t >= 100) fails++;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      rd(a);
      chk_val(rv, {24'h0, e});
      chk_resp(rs, er);
   endtask

   function automatic logic [7:0] pa(input int p, input int dir);
      return {6'(`GPEI_IDX_A_DATA + 2 * p + dir), 2'h0};
   endfunction

   // Expected data read: latch where driven, pin level elsewhere
   function automatic logic [7:0] exp_rd(input int p);
      gpei_pkg::gpei_alt_t al;
      logic [7:0]          e, l;
      al = p == 0 ? alt_a : (p == 1 ? alt_b : alt_c);
      e = m_dir[p] | al.drive;
      l = (ext_en[p*8+:8] & ext[p*8+:8]) | ~ext_en[p*8+:8];
      l = (e & m_lat[p]) | (~e & l);
      return p == 2 ? (l | `GPEI_C_UNUSED) : l;
   endfunction

   // Expected pin drive from direction, latch and peripheral
   task automatic chk_pins(input int p);
      gpei_pkg::gpei_alt_t al;
      logic [7:0]          eo, ee, o, oe, m;
      al = p == 0 ? alt_a : (p == 1 ? alt_b : alt_c);
      o = p == 0 ? pin_a_out : (p == 1 ? pin_b_out : {5'h0, pin_c_out});
      oe = p == 0 ? pin_a_oe : (p == 1 ? pin_b_oe : {5'h0, pin_c_oe});
      m = p == 2 ? 8'h07 : 8'hFF;
      ee = (al.drive & ~(al.od & al.value)) | (~al.drive & m_dir[p]);
      eo = (al.drive & ~al.od & al.value) | (~al.drive & m_lat[p]);
      chk_val({16'h0, oe & m, o & oe & m}, {16'h0, ee & m, eo & ee & m});
   endtask

   task automatic ack_pulse;
      @(posedge aclk);
      irq_ack <= 1'b1;
      @(posedge aclk);
      irq_ack <= 1'b0;
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'h13F1A02E));
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      chk_val({pin_a_oe, pin_b_oe, 5'h0, pin_c_oe, 8'h0}, 32'h0);
      for (int p = 0; p < 3; p++) begin
         m_lat[p] = 8'h00;
         m_dir[p] = 8'h00;
         rchk(pa(p, 0), exp_rd(p), `GPEI_RESP_OKAY);
         if (p < 2) rchk(pa(p, 1), 8'h00, `GPEI_RESP_OKAY);
      end
      rchk(en_addr, 8'h00, `GPEI_RESP_OKAY);
      rchk(8'h3C, 8'h00, `GPEI_RESP_SLVERR);
      wr(8'h3C, 8'hFF);
      chk_resp(rs, `GPEI_RESP_SLVERR);
      // Random latch and direction per port
      for (int i = 0; i < 6; i++) begin
         pb = i % 3;
         ext[pb*8+:8] <= 8'($urandom);
         if (pb != 1) ext_en[pb*8+:8] <= 8'($urandom);
         m_lat[pb] = 8'($urandom);
         m_dir[pb] = 8'($urandom);
         wr(pa(pb, 0), m_lat[pb]);
         wr(pa(pb, 1), m_dir[pb]);
         cyc(2);
         chk_pins(pb);
         rchk(pa(pb, 0), exp_rd(pb), `GPEI_RESP_OKAY);
         if (pb != 2) rchk(pa(pb, 1), m_dir[pb], `GPEI_RESP_OKAY);
      end
      wr(pa(0, 0), ~m_lat[0], 4'h0);
      chk_resp(rs, `GPEI_RESP_OKAY);
      rchk(pa(0, 0), exp_rd(0), `GPEI_RESP_OKAY);
      // Pins handed to peripherals stay inputs
      for (int p = 0; p < 3; p++) begin
         m_dir[p] = 8'h00;
         wr(pa(p, 1), 8'h00);
      end
      // Peripherals take every port, interrupts all disabled
      alt_a <= 24'($urandom) | 24'h040404;
      alt_b <= 24'($urandom) & 24'hFFFFFD | 24'h020000;
      alt_c <= 24'($urandom);
      cyc(3);
      for (int p = 0; p < 3; p++) begin
         chk_pins(p);
         rchk(pa(p, 0), exp_rd(p), `GPEI_RESP_OKAY);
      end
      alt_a <= '0;
      alt_b <= '0;
      alt_c <= '0;
      // Analog channel selection, left off afterwards
      for (int c = 0; c < 9; c++) begin
         adc_enable <= c < 8;
         adc_channel <= 3'(c);
         cyc(3);
         chk_val({24'h0, analog_sel}, c < 8 ? 32'h1 << c : 32'h0);
      end
      // Interrupt lines at idle, all inputs
      ext <= 24'h00C0C0;
      ext_en <= 24'hFFFFFF;
      cyc(6);
      wr(pend_addr, 8'hFF);
      for (int k = 0; k < 16; k++) begin
         ln = k % 8;
         pb = (ln / 4) * 8 + 4 + ln % 4;
         wr(en_addr, k < 8 ? 8'h1 << ln : 8'h00);
         ext[pb] <= ~ext[pb];
         cyc(8);
         rchk(pend_addr, k < 8 ? 8'h1 << ln : 8'h00, `GPEI_RESP_OKAY);
         chk_val({31'h0, irq_req}, {31'h0, k < 8});
         ack_pulse();
         ext[pb] <= ~ext[pb];
         cyc(8);
         rchk(pend_addr, 8'h00, `GPEI_RESP_OKAY);
      end
      // Global mask holds the request back
      cpu_irq_mask <= 1'b1;
      wr(en_addr, 8'h01);
      ext[4] <= 1'b1;
      cyc(8);
      chk_val({31'h0, irq_req}, 32'h0);
      rchk(pend_addr, 8'h01, `GPEI_RESP_OKAY);
      cpu_irq_mask <= 1'b0;
      cyc(3);
      chk_val({31'h0, irq_req}, 32'h1);
      wr(pend_addr, 8'h01);
      cyc(3);
      chk_val({31'h0, irq_req}, 32'h0);
      ext[4] <= 1'b0;
      // Frozen clock enable holds a new edge back until released
      cyc(4);
      ce <= 1'b0;
      ext[4] <= 1'b1;
      cyc(8);
      chk_val({31'h0, irq_req}, 32'h0);
      ce <= 1'b1;
      cyc(8);
      chk_val({31'h0, irq_req}, 32'h1);
      wr(pend_addr, 8'h01);
      ext[4] <= 1'b0;
      // High rising line hides its neighbour's edge
      wr(en_addr, 8'h03);
      ext[5] <= 1'b1;
      cyc(8);
      wr(pend_addr, 8'h02);
      ext[4] <= 1'b1;
      cyc(8);
      rchk(pend_addr, 8'h00, `GPEI_RESP_OKAY);
      ext[5:4] <= 2'b00;
      // Pin driven as output raises nothing
      wr(en_addr, 8'h01);
      m_lat[0] = 8'h10;
      wr(pa(0, 0), 8'h10);
      m_dir[0] = 8'h10;
      wr(pa(0, 1), 8'h10);
      cyc(8);
      chk_pins(0);
      rchk(pend_addr, 8'h00, `GPEI_RESP_OKAY);
      give_verdict();
   end

   // Cut a hung run short
   initial begin
      #500000;
      fails++;
      give_verdict();
   end
endmodule
